// ===== rtl/vps_pkg.sv
/*
  Package for the emulated PHY special control/status register: field
  positions, codes, reset values and carrier structs.
  Assumes one system clock domain and a synchronous active-high reset.
*/
package vps_pkg;

  // field positions within the low half-word
  localparam int VPS_BIT_COLL_TEST = 7;
  localparam int VPS_BIT_SPD_HI = 4;
  localparam int VPS_BIT_SPD_LO = 2;
  localparam int VPS_BIT_HB_OFF = 0;

  // speed/duplex codes
  localparam logic [2:0] VPS_SD_10_HALF = 3'h1;
  localparam logic [2:0] VPS_SD_100_HALF = 3'h2;
  localparam logic [2:0] VPS_SD_10_FULL = 3'h5;
  localparam logic [2:0] VPS_SD_100_FULL = 3'h6;

  // reset values
  localparam logic VPS_COLL_TEST_RST = 1'h0;

  // fields of the emulated phy basic control that this block watches
  typedef struct packed {
    logic emulated_autoneg_enable;
    logic emulated_speed_select_low;
    logic emulated_duplex_select;
    logic emulated_phy_soft_reset;
  } vps_basic_ctrl_t;

  // negotiated outcome from the emulated autoneg engine
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
  } vps_an_result_t;

  // register access port
  typedef struct packed {
    logic wr_en;
    logic [31:0] wr_data;
  } vps_reg_wr_t;

endpackage : vps_pkg

// ===== rtl/vps_special_ctrl.sv
/*
  Emulated PHY special control/status register, low half: collision test,
  speed/duplex indication and heartbeat test control.
  Assumes the host bus and MII management decoders present a write strobe
  with data when this register is addressed and consume read_data.
*/
// Functional notes
// - collision test bit set drives collision while the switch engine transmits.
// - speed/duplex codes 001,010,101,110 for 10H,100H,10F,100F.
// - autoneg on shows negotiated result, else basic control speed/duplex bits.
// - bit 0 heartbeat test off, default loaded from configuration strap.
// - reset-scoped bits restore defaults on emulated phy reset via reset regs, only while the soft reset bit is set.
// - bits 31-16 pad to 32 bits; management view is 16 bits wide.
`timescale 1ns/10ps
module vps_special_ctrl
  import vps_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // strap level, held stable through reset
  input wire logic heartbeat_test_disable_strap,
  // emulated phy reset pulse from reset or power-management control
  input wire logic phy_reset_req,
  // basic control fields and autoneg outcome
  input vps_basic_ctrl_t basic_ctrl,
  input vps_an_result_t an_result,
  // register access
  input vps_reg_wr_t reg_wr,
  output logic [31:0] read_data,
  output logic [15:0] mgmt_read_data,
  // switch fabric host port
  input wire logic engine_tx_active,
  output logic host_collision,
  output logic heartbeat_test_off
);

  // write and reset decode
  logic wr_take;
  logic wr_coll_bit;
  logic wr_hb_bit;
  logic phy_rst;

  // collision test control
  logic coll_test_r;
  logic coll_test_nxt;

  // heartbeat test control
  logic hb_off_r;
  logic hb_off_nxt;

  // speed/duplex indication
  logic sd_speed_100;
  logic sd_full_duplex;
  logic [2:0] spd_r;
  logic [2:0] spd_nxt;

  // collision toward the host port
  logic coll_r;
  logic coll_nxt;

  // register read view, one driver per bit
  wire logic [15:0] low_half;

  // only bits 7 and 0 are writable; every other written bit is dropped
  assign wr_take = reg_wr.wr_en;

  assign wr_coll_bit = reg_wr.wr_data[VPS_BIT_COLL_TEST];

  assign wr_hb_bit = reg_wr.wr_data[VPS_BIT_HB_OFF];

  // reset-scoped bits restore only when the soft reset bit is set
  assign phy_rst = phy_reset_req & basic_ctrl.emulated_phy_soft_reset;

  // collision test control: written by software, not reset-scoped
  always_comb begin
    coll_test_nxt = coll_test_r;
    if (wr_take) begin
      coll_test_nxt = wr_coll_bit;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      coll_test_r <= VPS_COLL_TEST_RST;
    end else begin
      coll_test_r <= coll_test_nxt;
    end
  end

  // heartbeat control: an effective phy reset beats a same-cycle write
  always_comb begin
    hb_off_nxt = hb_off_r;
    if (wr_take) begin
      hb_off_nxt = wr_hb_bit;
    end
    if (phy_rst) begin
      hb_off_nxt = heartbeat_test_disable_strap;
    end
  end

  // strap is sampled by the clocked reset, never an async load
  always_ff @(posedge mclk) begin
    if (srst) begin
      hb_off_r <= heartbeat_test_disable_strap;
    end else begin
      hb_off_r <= hb_off_nxt;
    end
  end

  // speed/duplex source: negotiated outcome or the basic control bits
  always_comb begin
    if (basic_ctrl.emulated_autoneg_enable) begin
      sd_speed_100 = an_result.speed_100;
      sd_full_duplex = an_result.full_duplex;
    end else begin
      sd_speed_100 = basic_ctrl.emulated_speed_select_low;
      sd_full_duplex = basic_ctrl.emulated_duplex_select;
    end
  end

  // only the four legal codes are ever produced
  always_comb begin
    unique case ({sd_speed_100, sd_full_duplex})
      2'h0: begin
        spd_nxt = VPS_SD_10_HALF;
      end
      2'h1: begin
        spd_nxt = VPS_SD_10_FULL;
      end
      2'h2: begin
        spd_nxt = VPS_SD_100_HALF;
      end
      2'h3: begin
        spd_nxt = VPS_SD_100_FULL;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      spd_r <= VPS_SD_10_HALF;
    end else begin
      spd_r <= spd_nxt;
    end
  end

  // collision follows the engine one clock late while the test bit is set
  always_comb begin
    coll_nxt = 1'h0;
    if (coll_test_nxt) begin
      coll_nxt = engine_tx_active;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      coll_r <= 1'h0;
    end else begin
      coll_r <= coll_nxt;
    end
  end

  // read view assembled bit by bit from the stored fields
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 16; bit_idx++) begin : g_low_bit
      if (bit_idx == VPS_BIT_COLL_TEST) begin : g_coll
        assign low_half[bit_idx] = coll_test_r;
      end else if (bit_idx == VPS_BIT_HB_OFF) begin : g_hb
        assign low_half[bit_idx] = hb_off_r;
      end else if (bit_idx >= VPS_BIT_SPD_LO &&
                   bit_idx <= VPS_BIT_SPD_HI) begin : g_spd
        assign low_half[bit_idx] = spd_r[bit_idx - VPS_BIT_SPD_LO];
      end else begin : g_rsv
        assign low_half[bit_idx] = 1'h0;
      end
    end
  endgenerate

  // host bus sees a padded word, management sees the low half only
  assign read_data = {16'h0000, low_half};

  assign mgmt_read_data = low_half;

  // outputs toward the host port and the phy core
  assign host_collision = coll_r;

  assign heartbeat_test_off = hb_off_r;

endmodule : vps_special_ctrl

// ===== bench/vps_checker.sv
/* checker for vps_special_ctrl; bound to it, sees its ports only */
`timescale 1ns/10ps
module vps_checker
  import vps_pkg::*;
(
  input logic mclk, srst, heartbeat_test_disable_strap, phy_reset_req,
  input logic engine_tx_active, host_collision, heartbeat_test_off,
  input vps_basic_ctrl_t basic_ctrl,
  input vps_an_result_t an_result,
  input vps_reg_wr_t reg_wr,
  input logic [31:0] read_data,
  input logic [15:0] mgmt_read_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire [31:0] r = read_data;
  wire w = reg_wr.wr_en;
  wire p = phy_reset_req & basic_ctrl.emulated_phy_soft_reset;
  // speed bit high, duplex bit low, in both sources
  wire [1:0] m = basic_ctrl[3] ? 2'(an_result) : basic_ctrl[2:1];
  sequence s_arm;
    r[7] && engine_tx_active && !w;
  endsequence
  chk_sd_follow:
    assert property (1 |=> r[4:2] == $past({m[0], m[1], !m[1]})) else $error("sd");
  chk_rsv_zero: assert property ((r & 32'hFFFFFF62) == 32'h0)
    else $error("reserved bits set");
  chk_mgmt_view: assert property (mgmt_read_data == r[15:0])
    else $error("mgmt view");
  chk_hb_write:
    assert property (w && !p |=> heartbeat_test_off == $past(reg_wr.wr_data[0]))
    else $error("hb write");
  chk_phy_reset:
    assert property (p |=> r[0] == $past(heartbeat_test_disable_strap))
    else $error("phy reset");
  chk_coll_write: assert property (w |=> r[7] == $past(reg_wr.wr_data[7]))
    else $error("coll test write");
  chk_coll_on: assert property (s_arm |=> host_collision)
    else $error("no collision");
  chk_coll_off: assert property (!engine_tx_active |=> !host_collision)
    else $error("stray collision");
endmodule : vps_checker
bind vps_special_ctrl vps_checker u_chk (.*);

// ===== bench/vps_fabric_model.sv
/* switch engine side: random transmit bursts; assumes one clock */
`timescale 1ns/10ps
module vps_fabric_model (
  input logic mclk,
  output logic engine_tx_active
);
  initial engine_tx_active = 1'h0;
  always @(negedge mclk) if ($urandom % 4 == 0) engine_tx_active <= !engine_tx_active;
endmodule : vps_fabric_model

// ===== bench/testbench.sv
/* bench for vps_special_ctrl; assumes checker and fabric model */
`timescale 1ns/10ps
module testbench;
  import vps_pkg::*;
  logic mclk = 0, srst = 1, s = 1, q = 0, tx, c, h;
  vps_basic_ctrl_t b = '0;
  vps_an_result_t a = '0;
  vps_reg_wr_t w = '0;
  logic [31:0] rd, e = '0;
  logic ec = 0;
  logic [15:0] md;
  int fail_count = 0, num_checks = 0;
  always #4 mclk = ~mclk;
  vps_fabric_model u_fab (.mclk, .engine_tx_active(tx));
  vps_special_ctrl u_dut (.mclk, .srst, .heartbeat_test_disable_strap(s),
    .phy_reset_req(q), .basic_ctrl(b), .an_result(a), .reg_wr(w),
    .read_data(rd), .mgmt_read_data(md), .engine_tx_active(tx),
    .host_collision(c), .heartbeat_test_off(h));
  function automatic logic [2:0] sd_of(logic [1:0] m);
    return {m[0], m[1], !m[1]};
  endfunction : sd_of
  always @(posedge mclk) begin
    e[4:2] <= srst ? 3'h1 : sd_of(b[3] ? 2'(a) : b[2:1]);
    if (srst || q && b[0]) e[0] <= s;
    else if (w.wr_en) e[0] <= w.wr_data[0];
    ec <= !srst && (w.wr_en ? w.wr_data[7] : e[7]) && tx;
    if (srst) e[7] <= 1'h0;
    else if (w.wr_en) e[7] <= w.wr_data[7];
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    void'($urandom(32'hADBA7B0B));
    repeat (12) @(negedge mclk);
    srst = 0;
    for (int i = 0; i < 900; i++) begin
      @(negedge mclk);
      num_checks++;
      if (rd !== e || md !== e[15:0]) begin
        fail_count++;
        $display("unexpected %0t %h %h", $time, rd, e);
      end
      num_checks++;
      if (c !== ec || h !== e[0]) begin
        fail_count++;
        $display("unexpected %0t %h %h", $time, {c, h}, {ec, e[0]});
      end
      {b, a, s, q} = 8'($urandom);
      srst = i % 400 > 396;
      w.wr_en = $urandom % 3 == 0 && i % 400 inside {[1:395]};
      w.wr_data = i % 64 ? $urandom : 32'hFFFFFFFF;
    end
    $display("test random done");
    stop_test;
  end
  initial begin
    #20000;
    fail_count++;
    stop_test;
  end
endmodule : testbench
